/* File: hdl/netcfg_pkg.sv */
// Contract
// - Bit 0 device partial checksum, 1 driver; 7-10 driver rx segmentation, 11-14 device.
// - Bit 3 reports a transfer unit; once agreed the driver keeps under it.
// - Bit 5 station address, 15 merged receive buffers, 16 link-state field present.
// - Bits 17 control queue, 18 rx mode, 19 VLAN, 21 announce, 22 multiqueue, 23 address set.
// - Bits 56 UDP segment, 57 hash report, 59 header length, 60 steering, 61-63 as listed.
// - Bits 6, 41, 42 are legacy only; bit 41 is never offered.
// - Driver TSO4/TSO6/UFO need driver checksum; driver ECN needs driver TSO4 or TSO6.
// - Device TSO4/TSO6/UFO/USO need device checksum; device ECN, coalescing need TSO4 or TSO6.
// - Rx mode, VLAN, announce, multiqueue, address set, steering all need the control queue.
// - Config fields read-only; address always present; link-state only with its feature.
// - Link-state bit value 1 means link up, value 2 requests an announcement.
// - Queue-pair limit 1 to 0x8000, present only with multiqueue or steering.
// - Transfer unit 68 to 65535 when offered, and at least 1280.
// - The transfer unit never changes once set.
// - With transfer unit agreed, oversize received none/ECN packets are never delivered.
// - With transfer unit agreed, transmitted none/ECN packets up to the limit are forwarded whole.
// - Speed in 1 Mbit/s units, 0 to 0x7fffffff, 0xffffffff unknown.
// - Duplex 0x01 full, 0x00 half, 0xff unknown.
// - With speed reporting and link state agreed, speed and duplex hold while link up.
// - Key-size field at least 40 with steering or hash reporting.
// - Indirection table at least 128 entries of 16 bits with steering.
// - Hash-type bitmask present with steering or hash reporting.
package netcfg_pkg;

    // ------------------------------------------------------------
    // Feature bit positions
    // ------------------------------------------------------------
    localparam int F_DEV_CSUM      = 0;
    localparam int F_DRV_CSUM      = 1;
    localparam int F_CTRL_OFFLOAD  = 2;
    localparam int F_MTU           = 3;
    localparam int F_STATION_ADDR  = 5;
    localparam int F_LEGACY_GSO    = 6;
    localparam int F_DRV_TCP4      = 7;
    localparam int F_DRV_TCP6      = 8;
    localparam int F_DRV_ECN       = 9;
    localparam int F_DRV_UFO       = 10;
    localparam int F_DEV_TCP4      = 11;
    localparam int F_DEV_TCP6      = 12;
    localparam int F_DEV_ECN       = 13;
    localparam int F_DEV_UFO       = 14;
    localparam int F_MERGED_RXBUF  = 15;
    localparam int F_LINK_STATE    = 16;
    localparam int F_CTRL_QUEUE    = 17;
    localparam int F_CTRL_RXMODE   = 18;
    localparam int F_CTRL_VLAN     = 19;
    localparam int F_DRV_ANNOUNCE  = 21;
    localparam int F_MULTI_QUEUE   = 22;
    localparam int F_CTRL_ADDR_SET = 23;
    localparam int F_LEGACY_COAL4  = 41;
    localparam int F_LEGACY_COAL6  = 42;
    localparam int F_DEV_USO       = 56;
    localparam int F_HASH_REPORT   = 57;
    localparam int F_DRV_HDRLEN    = 59;
    localparam int F_STEERING      = 60;
    localparam int F_EXT_COALESCE  = 61;
    localparam int F_STANDBY       = 62;
    localparam int F_SPEED_DUPLEX  = 63;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] A_CFG0      = 8'h00; // address bytes 0-3
    localparam logic [7:0] A_CFG1      = 8'h04; // address 4-5, link state
    localparam logic [7:0] A_CFG2      = 8'h08; // queue pairs, transfer unit
    localparam logic [7:0] A_CFG3      = 8'h0c; // link rate
    localparam logic [7:0] A_CFG4      = 8'h10; // duplex, key size, table len
    localparam logic [7:0] A_CFG5      = 8'h14; // hash type mask
    localparam logic [7:0] A_DEV_FLO   = 8'h20;
    localparam logic [7:0] A_DEV_FHI   = 8'h24;
    localparam logic [7:0] A_DRV_FLO   = 8'h28;
    localparam logic [7:0] A_DRV_FHI   = 8'h2c;
    localparam logic [7:0] A_NEG_CTRL  = 8'h30;

    localparam int NC_COMMIT   = 0;  // write 1: agree the driver set
    localparam int NC_ERROR    = 1;  // read: last commit was refused (asked for an unoffered bit or broke a dependency)
    localparam int NC_ANN_CLR  = 2;  // write 1: clear announce request

    // ------------------------------------------------------------
    // Field codes and limits
    // ------------------------------------------------------------
    localparam int          ST_LINK_UP    = 0;
    localparam int          ST_ANNOUNCE   = 1;
    localparam logic [7:0]  DUPLEX_FULL   = 8'h01;
    localparam logic [7:0]  DUPLEX_HALF   = 8'h00;
    localparam logic [7:0]  DUPLEX_UNKN   = 8'hff;
    localparam logic [31:0] SPEED_MAX     = 32'h7fffffff;
    localparam logic [31:0] SPEED_UNKN    = 32'hffffffff;
    localparam logic [7:0]  GSO_NONE      = 8'h00;
    localparam logic [7:0]  GSO_ECN       = 8'h80;
    localparam int          QP_MIN        = 1;
    localparam int          QP_MAX        = 32'h8000;
    localparam int          MTU_MIN       = 68;
    localparam int          MTU_MAX       = 65535;
    localparam int          MTU_ADVISED   = 1280;
    localparam int          KEY_MIN       = 40;
    localparam int          TABLE_MIN     = 128;
    localparam int          L2_HDR_LEN    = 14;

    // ------------------------------------------------------------
    // Dependency check shared by offered and agreed sets
    // ------------------------------------------------------------
    function automatic logic dep_ok(input logic [63:0] f);
        logic ctl;
        ctl = f[F_CTRL_QUEUE];
        dep_ok = !((f[F_DRV_TCP4] | f[F_DRV_TCP6] | f[F_DRV_UFO]) & !f[F_DRV_CSUM])
            && !(f[F_DRV_ECN] & !(f[F_DRV_TCP4] | f[F_DRV_TCP6]))
            && !((f[F_DEV_TCP4] | f[F_DEV_TCP6] | f[F_DEV_UFO] | f[F_DEV_USO])
                 & !f[F_DEV_CSUM])
            && !((f[F_DEV_ECN] | f[F_EXT_COALESCE])
                 & !(f[F_DEV_TCP4] | f[F_DEV_TCP6]))
            && !((f[F_CTRL_RXMODE] | f[F_CTRL_VLAN] | f[F_DRV_ANNOUNCE]
                 | f[F_MULTI_QUEUE] | f[F_CTRL_ADDR_SET] | f[F_STEERING]) & !ctl);
    endfunction

endpackage

/* File: hdl/agreed_if.sv */
`timescale 1ns/1ps
// Transfer-unit agreed flag and the fixed transfer unit, passed to the size gate.
interface agreed_if;
    logic        mtu_agreed;
    logic [15:0] mtu;
    modport src (output mtu_agreed, output mtu);
    modport dst (input mtu_agreed, input mtu);
endinterface

/* File: hdl/feature_dep_check.sv */
`timescale 1ns/1ps
module feature_dep_check (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        check,
    input  wire logic [63:0] want,
    input  wire logic [63:0] offered,
    output logic             accept,
    output logic             reject
);
    // A set is refused when it asks for anything not offered or breaks a dependency.
    wire legal = ((want & ~offered) == 64'h0) && netcfg_pkg::dep_ok(want);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            accept <= 1'b0;
            reject <= 1'b0;
        end
        else
        begin
            accept <= check & legal;
            reject <= check & !legal;
        end
    end
endmodule // feature_dep_check

/* File: hdl/frame_size_gate.sv */
`timescale 1ns/1ps
module frame_size_gate (
    input  wire logic        pclk,
    input  wire logic        presetn,
    agreed_if.dst            agr,
    input  wire logic        pkt_valid,
    input  wire logic        pkt_is_tx,
    input  wire logic [15:0] pkt_len,
    input  wire logic [7:0]  pkt_gso,
    output logic             pass_r,
    output logic             drop_r
);
    // ------------------------------------------------------------
    // Size limit
    // ------------------------------------------------------------
    // The limit is widened by one bit so an MTU of 65535 plus header cannot wrap.
    wire [16:0] limit    = {1'b0, agr.mtu} + 17'(netcfg_pkg::L2_HDR_LEN);
    wire        plain    = (pkt_gso == netcfg_pkg::GSO_NONE) || (pkt_gso == netcfg_pkg::GSO_ECN);
    wire        oversize = agr.mtu_agreed && plain && ({1'b0, pkt_len} > limit);
    // Received oversize frames are dropped; transmit frames within the limit always pass.
    wire        drop     = !pkt_is_tx && oversize;
    wire        pass     = !drop;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pass_r <= 1'b0;
            drop_r <= 1'b0;
        end
        else
        begin
            pass_r <= pkt_valid & pass;
            drop_r <= pkt_valid & drop;
        end
    end
endmodule // frame_size_gate

/* File: hdl/net_feature_config_space.sv */
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module net_feature_config_space #(
    parameter logic [63:0] OFFERED      = 64'h9000_0000_0063_f82b,
    parameter logic [47:0] STATION_ADDR = 48'h02_00_00_00_00_01, // arbitrary
    parameter int          QUEUE_PAIRS  = 4,
    parameter int          MTU_VALUE    = 1500,
    parameter int          KEY_BYTES    = 40,
    parameter int          TABLE_LEN    = 128,
    parameter logic [31:0] HASH_TYPES   = 32'h0000_003f
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Link side
    input  wire logic        link_up,
    input  wire logic        announce_event,
    input  wire logic [31:0] link_speed,
    input  wire logic [7:0]  link_duplex,
    // Packet size checks
    input  wire logic        pkt_valid,
    input  wire logic        pkt_is_tx,
    input  wire logic [15:0] pkt_len,
    input  wire logic [7:0]  pkt_gso,
    output logic             pkt_pass,
    output logic             pkt_drop,
    // Agreed state
    output logic             features_ok,
    output logic [63:0]      agreed_features
);

    // ------------------------------------------------------------
    // Elaboration checks on the offered set and fixed fields
    // ------------------------------------------------------------
    if (!netcfg_pkg::dep_ok(OFFERED))
        $error("offered feature set breaks a dependency");
    if (OFFERED[netcfg_pkg::F_LEGACY_COAL4] || OFFERED[netcfg_pkg::F_LEGACY_COAL6]
        || OFFERED[netcfg_pkg::F_LEGACY_GSO])
        $error("legacy feature bit offered");
    if (QUEUE_PAIRS < netcfg_pkg::QP_MIN || QUEUE_PAIRS > netcfg_pkg::QP_MAX)
        $error("queue pair limit out of range");
    if (MTU_VALUE < netcfg_pkg::MTU_ADVISED || MTU_VALUE > netcfg_pkg::MTU_MAX)
        $error("transfer unit out of range");
    if (KEY_BYTES < netcfg_pkg::KEY_MIN || KEY_BYTES > 255)
        $error("steering key size out of range");
    if (TABLE_LEN < netcfg_pkg::TABLE_MIN || TABLE_LEN > 65535)
        $error("indirection table length out of range");

    // ------------------------------------------------------------
    // Offered feature decode
    // ------------------------------------------------------------
    wire off_link   = OFFERED[netcfg_pkg::F_LINK_STATE];
    wire off_mtu    = OFFERED[netcfg_pkg::F_MTU];
    wire off_qp     = OFFERED[netcfg_pkg::F_MULTI_QUEUE] | OFFERED[netcfg_pkg::F_STEERING];
    wire off_sd     = OFFERED[netcfg_pkg::F_SPEED_DUPLEX];
    wire off_rss    = OFFERED[netcfg_pkg::F_STEERING];
    wire off_hash   = OFFERED[netcfg_pkg::F_STEERING] | OFFERED[netcfg_pkg::F_HASH_REPORT];

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [63:0] drv_feat_r;
    logic [63:0] agreed_r;
    logic        ok_r;
    logic        err_r;
    logic        announce_r;
    logic [15:0] mtu_r;
    logic        mtu_set_r;
    logic [31:0] speed_r;
    logic [7:0]  duplex_r;
    logic        link_r;
    logic        pready_r;
    logic [31:0] prdata_r;
    logic        pslverr_r;
    logic        commit;
    logic        dep_accept;
    logic        dep_reject;

    agreed_if agr ();

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // Every access takes one wait state so the answer comes straight from flops.
    wire acc     = psel & penable & !pready_r;
    // A write lands only at the edge that completes the transfer, with pready seen high.
    wire wr      = psel & penable & pready_r & pwrite;
    wire hit_cfg = (paddr <= netcfg_pkg::A_CFG5) && (paddr[1:0] == 2'b00);
    wire hit_own = (paddr == netcfg_pkg::A_DEV_FLO) || (paddr == netcfg_pkg::A_DEV_FHI)
                || (paddr == netcfg_pkg::A_DRV_FLO) || (paddr == netcfg_pkg::A_DRV_FHI)
                || (paddr == netcfg_pkg::A_NEG_CTRL);
    wire mapped  = hit_cfg | hit_own;
    wire wr_dlo  = wr && (paddr == netcfg_pkg::A_DRV_FLO);
    wire wr_dhi  = wr && (paddr == netcfg_pkg::A_DRV_FHI);
    wire wr_ctl  = wr && (paddr == netcfg_pkg::A_NEG_CTRL);
    // Config field writes fall through here with no effect and no error.
    assign commit = wr_ctl & pwdata[netcfg_pkg::NC_COMMIT];
    wire ann_clr = wr_ctl & pwdata[netcfg_pkg::NC_ANN_CLR];

    // ------------------------------------------------------------
    // Negotiation
    // ------------------------------------------------------------
    feature_dep_check u_dep (
        .pclk    (pclk),
        .presetn (presetn),
        .check   (commit),
        .want    (drv_feat_r),
        .offered (OFFERED),
        .accept  (dep_accept),
        .reject  (dep_reject)
    );

    wire neg_sd   = agreed_r[netcfg_pkg::F_SPEED_DUPLEX];
    wire neg_link = agreed_r[netcfg_pkg::F_LINK_STATE];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            drv_feat_r <= 64'h0;
            agreed_r   <= 64'h0;
            ok_r       <= 1'b0;
            err_r      <= 1'b0;
        end
        else
        begin
            if (wr_dlo)
                drv_feat_r[31:0] <= pwdata;
            if (wr_dhi)
                drv_feat_r[63:32] <= pwdata;
            if (dep_accept)
            begin
                agreed_r <= drv_feat_r;
                ok_r     <= 1'b1;
                err_r    <= 1'b0;
            end
            else if (dep_reject)
            begin
                agreed_r <= 64'h0;
                ok_r     <= 1'b0;
                err_r    <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Link state, announce request and link rate
    // ------------------------------------------------------------
    // A new announce event wins over a clear in the same cycle.
    wire announce_nxt = announce_event | (announce_r & !ann_clr);
    // Rate and duplex freeze while the link is up once both features are agreed.
    wire hold_rate = neg_sd & neg_link & link_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            announce_r <= 1'b0;
            link_r     <= 1'b0;
            speed_r    <= netcfg_pkg::SPEED_UNKN;
            duplex_r   <= netcfg_pkg::DUPLEX_UNKN;
        end
        else
        begin
            announce_r <= announce_nxt;
            link_r     <= link_up;
            if (!hold_rate)
            begin
                // Out-of-range inputs are reported as unknown.
                speed_r  <= (link_speed > netcfg_pkg::SPEED_MAX)
                            ? netcfg_pkg::SPEED_UNKN : link_speed;
                duplex_r <= (link_duplex == netcfg_pkg::DUPLEX_FULL
                             || link_duplex == netcfg_pkg::DUPLEX_HALF)
                            ? link_duplex : netcfg_pkg::DUPLEX_UNKN;
            end
        end
    end

    // ------------------------------------------------------------
    // Transfer unit, loaded once after reset release
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mtu_r     <= 16'h0;
            mtu_set_r <= 1'b0;
        end
        else if (!mtu_set_r)
        begin
            mtu_r     <= 16'(MTU_VALUE);
            mtu_set_r <= 1'b1;
        end
    end

    assign agr.mtu_agreed = agreed_r[netcfg_pkg::F_MTU] & mtu_set_r;
    assign agr.mtu        = mtu_r;

    frame_size_gate u_gate (
        .pclk      (pclk),
        .presetn   (presetn),
        .agr       (agr),
        .pkt_valid (pkt_valid),
        .pkt_is_tx (pkt_is_tx),
        .pkt_len   (pkt_len),
        .pkt_gso   (pkt_gso),
        .pass_r    (pkt_pass),
        .drop_r    (pkt_drop)
    );

    // ------------------------------------------------------------
    // Configuration field view, packed little-endian
    // ------------------------------------------------------------
    // Absent fields read as zero; the address field is always present.
    wire [47:0] f_addr   = STATION_ADDR;
    wire [15:0] f_status = off_link ? {14'h0, announce_r, link_r} : 16'h0;
    wire [15:0] f_qp     = off_qp ? 16'(QUEUE_PAIRS) : 16'h0;
    wire [15:0] f_mtu    = off_mtu ? mtu_r : 16'h0;
    wire [31:0] f_speed  = off_sd ? speed_r : 32'h0;
    wire [7:0]  f_duplex = off_sd ? duplex_r : 8'h0;
    wire [7:0]  f_key    = off_hash ? 8'(KEY_BYTES) : 8'h0;
    wire [15:0] f_table  = off_rss ? 16'(TABLE_LEN) : 16'h0;
    wire [31:0] f_hash   = off_hash ? HASH_TYPES : 32'h0;

    // Address bytes sit first, lowest byte in the lowest lane.
    wire [31:0] w_cfg0 = f_addr[31:0];
    wire [31:0] w_cfg1 = {f_status, f_addr[47:32]};
    wire [31:0] w_cfg2 = {f_mtu, f_qp};
    wire [31:0] w_cfg4 = {f_table, f_key, f_duplex};
    wire [31:0] w_ctl  = {29'h0, 1'b0, err_r, ok_r};

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb
    begin
        case (paddr)
            netcfg_pkg::A_CFG0:     rd_mux = w_cfg0;
            netcfg_pkg::A_CFG1:     rd_mux = w_cfg1;
            netcfg_pkg::A_CFG2:     rd_mux = w_cfg2;
            netcfg_pkg::A_CFG3:     rd_mux = f_speed;
            netcfg_pkg::A_CFG4:     rd_mux = w_cfg4;
            netcfg_pkg::A_CFG5:     rd_mux = f_hash;
            netcfg_pkg::A_DEV_FLO:  rd_mux = OFFERED[31:0];
            netcfg_pkg::A_DEV_FHI:  rd_mux = OFFERED[63:32];
            netcfg_pkg::A_DRV_FLO:  rd_mux = drv_feat_r[31:0];
            netcfg_pkg::A_DRV_FHI:  rd_mux = drv_feat_r[63:32];
            netcfg_pkg::A_NEG_CTRL: rd_mux = w_ctl;
            default:                rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r  <= acc;
            pslverr_r <= acc & !mapped;
            if (acc & !pwrite)
                prdata_r <= rd_mux;
        end
    end

    assign pready          = pready_r;
    assign prdata          = prdata_r;
    assign pslverr         = pslverr_r;
    assign features_ok     = ok_r;
    assign agreed_features = agreed_r;

endmodule // net_feature_config_space

/* File: bench/net_feature_config_space_assertions.sv */
`timescale 1ns/1ps
module cfg_space_checker #(
    parameter int MTU_VALUE = 1500
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pkt_valid,
    input wire logic        pkt_is_tx,
    input wire logic [15:0] pkt_len,
    input wire logic [7:0]  pkt_gso,
    input wire logic        pkt_pass,
    input wire logic        pkt_drop,
    input wire logic [63:0] agreed_features
);
    // ------------------------------------------------------------
    // Size gate and register checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire big = pkt_len > 16'(MTU_VALUE + 14);
    wire cut = pkt_gso == 8'h00 || pkt_gso == 8'h80;
    wire [5:0] ctl = {agreed_features[60], agreed_features[23:21], agreed_features[19:18]};
    property p_wait_one; psel && penable && !pready |=> pready; endproperty
    property p_ready_pulse; pready |=> !pready; endproperty
    property p_mtu_read; pready && !pwrite && paddr == 8'h08 |-> prdata[31:16] == 16'(MTU_VALUE);
    endproperty
    property p_answer; pkt_valid |=> pkt_pass != pkt_drop; endproperty
    property p_quiet; !pkt_valid |=> !pkt_pass && !pkt_drop; endproperty
    property p_rx_drop; pkt_valid && !pkt_is_tx && agreed_features[3] && cut && big |=> pkt_drop;
    endproperty
    property p_forward; pkt_valid && (pkt_is_tx || !big) |=> pkt_pass; endproperty
    property p_no_41; agreed_features[41] == 1'h0; endproperty
    property p_ctl_dep; (|ctl) |-> agreed_features[17]; endproperty
    a_wait_one: assert property (p_wait_one) else $error("no answer after one wait");
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held high");
    a_mtu_read: assert property (p_mtu_read) else $error("transfer unit changed");
    a_answer: assert property (p_answer) else $error("packet answer missing");
    a_quiet: assert property (p_quiet) else $error("spurious packet answer");
    a_rx_drop: assert property (p_rx_drop) else $error("oversize rx delivered");
    a_forward: assert property (p_forward) else $error("packet not forwarded");
    a_no_41: assert property (p_no_41) else $error("legacy bit agreed");
    a_ctl_dep: assert property (p_ctl_dep) else $error("control queue missing");
    c_drop: cover property (pkt_valid ##1 pkt_drop);
    c_read: cover property (pready && !pwrite);
    c_agree: cover property ($rose(agreed_features[3]));
endmodule // cfg_space_checker
bind net_feature_config_space cfg_space_checker #(.MTU_VALUE(MTU_VALUE)) u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pready(pready), .prdata(prdata), .pkt_valid(pkt_valid), .pkt_is_tx(pkt_is_tx),
    .pkt_len(pkt_len), .pkt_gso(pkt_gso), .pkt_pass(pkt_pass), .pkt_drop(pkt_drop),
    .agreed_features(agreed_features));

/* File: bench/net_feature_config_space_tb_top.sv */
`timescale 1ns/1ps
module net_feature_config_space_tb_top;
    logic        pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, link_up = '0;
    logic        announce_event = '0, pkt_valid = '0, pkt_is_tx = '0;
    logic [7:0]  paddr = '0, link_duplex = '0, pkt_gso = '0, g;
    logic [15:0] pkt_len = '0;
    logic [31:0] pwdata = '0, link_speed = '0, rnd = 32'h8b4d, spd;
    wire  [31:0] prdata;
    wire         pready, pslverr, pkt_pass, pkt_drop, features_ok;
    wire  [63:0] agreed_features;
    int          fail_count = 0, checked = 0, i, n;
    logic [33:0] bq[$];
    logic        pq[$];
    net_feature_config_space u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .link_up(link_up), .announce_event(announce_event),
        .link_speed(link_speed), .link_duplex(link_duplex), .pkt_valid(pkt_valid),
        .pkt_is_tx(pkt_is_tx), .pkt_len(pkt_len), .pkt_gso(pkt_gso), .pkt_pass(pkt_pass),
        .pkt_drop(pkt_drop), .features_ok(features_ok), .agreed_features(agreed_features));
    // ------------------------------------------------------------
    // Drivers, monitor and checks
    // ------------------------------------------------------------
    initial forever #5 pclk = ~pclk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input string nm, input logic [63:0] e, input logic [63:0] s);
        checked++;
        if (s !== e)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task results();
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // The note is queued before the request, so the monitor never sees an answer first.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic er,
             input logic [31:0] e);
        bq.push_back({w, er, e});
        psel <= 1'h1;
        {pwrite, paddr, pwdata} <= {w, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        for (n = 0; n < 20 && pready !== 1'h1; n++) @(posedge pclk);
        fail_count += (n == 20);
        if (n == 20) results();
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task pkt(input logic tx, input logic [15:0] len, input logic [7:0] gs, input logic dr);
        pq.push_back(dr);
        pkt_valid <= 1'h1;
        {pkt_is_tx, pkt_len, pkt_gso} <= {tx, len, gs};
        @(posedge pclk);
        pkt_valid <= 1'h0;
        @(posedge pclk);
    endtask
    always @(posedge pclk)
    begin
        if (pready === 1'h1 && bq.size() > 0)
        begin
            chk("pslverr", bq[0][32], pslverr);
            if (bq[0][33] == 1'h0) chk("prdata", bq[0][31:0], prdata);
            void'(bq.pop_front());
        end
        if ((pkt_pass | pkt_drop) === 1'h1 && pq.size() > 0)
        begin
            chk("pkt_drop", pq[0], pkt_drop);
            chk("pkt_pass", !pq[0], pkt_pass);
            void'(pq.pop_front());
        end
    end
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        link_up <= 1'h1;
        repeat (2) @(posedge pclk);
        apb(0, 8'h00, 0, 0, 32'h0000_0001);
        apb(0, 8'h04, 0, 0, 32'h0001_0200);
        apb(0, 8'h08, 0, 0, 32'h05dc_0004);
        apb(0, 8'h14, 0, 0, 32'h0000_003f);
        apb(0, 8'h20, 0, 0, 32'h0063_f82b);
        apb(0, 8'h24, 0, 0, 32'h9000_0000);
        apb(1, 8'h08, 32'hffff_ffff, 0, 0);
        apb(0, 8'h08, 0, 0, 32'h05dc_0004);
        apb(1, 8'h40, 0, 1, 0);
        apb(0, 8'h40, 0, 1, 0);
        for (i = 0; i < 6; i++)
        begin
            rnd = lfsr(rnd);
            spd = rnd ^ {i[0], 31'h0};
            {link_speed, link_duplex} <= {spd, 6'h0, rnd[9:8]};
            repeat (3) @(posedge pclk);
            spd = spd[31] ? 32'hffff_ffff : spd;
            apb(0, 8'h0c, 0, 0, spd);
            apb(0, 8'h10, 0, 0, {16'h0080, 8'h28, rnd[9] ? 8'hff : {7'h0, rnd[8]}});
        end
        pkt(0, 16'h05eb, 8'h00, 0);
        apb(1, 8'h28, 32'h0000_2001, 0, 0);
        apb(1, 8'h30, 32'h1, 0, 0);
        apb(0, 8'h30, 0, 0, 32'h2);
        apb(1, 8'h28, 32'h0040_0000, 0, 0);
        apb(1, 8'h30, 32'h1, 0, 0);
        apb(0, 8'h30, 0, 0, 32'h2);
        apb(1, 8'h28, 32'h0003_0009, 0, 0);
        apb(1, 8'h2c, 32'h8000_0000, 0, 0);
        apb(1, 8'h30, 32'h1, 0, 0);
        apb(0, 8'h30, 0, 0, 32'h1);
        chk("agreed", 64'h8000_0000_0003_0009, agreed_features);
        chk("features_ok", 1, features_ok);
        link_speed <= 32'h0000_0064;
        repeat (3) @(posedge pclk);
        apb(0, 8'h0c, 0, 0, spd);
        link_up <= 1'h0;
        repeat (3) @(posedge pclk);
        apb(0, 8'h0c, 0, 0, 32'h0000_0064);
        announce_event <= 1'h1;
        @(posedge pclk);
        announce_event <= 1'h0;
        apb(0, 8'h04, 0, 0, 32'h0002_0200);
        apb(1, 8'h30, 32'h4, 0, 0);
        apb(0, 8'h04, 0, 0, 32'h0000_0200);
        $display("register tests done");
        // Boundary lengths first, then random lengths and segmentation kinds.
        for (i = 0; i < 20; i++)
        begin
            rnd = lfsr(rnd);
            g = i < 12 ? (i < 4 ? 8'h00 : i < 8 ? 8'h80 : 8'h01) : rnd[23:16] & 8'h81;
            spd = i < 12 ? {16'h0, 16'h05ea + 16'(i[1])} : {16'h0, rnd[15:0]};
            pkt(i[0], spd[15:0], g, !i[0] && (g == 8'h00 || g == 8'h80) && spd > 32'h05ea);
        end
        repeat (4) @(posedge pclk);
        chk("pending", 0, 64'(bq.size() + pq.size()));
        $display("packet tests done");
        results();
    end
endmodule // net_feature_config_space_tb_top
